// ==== rtl/tae_pkg.sv ====
// constants and helpers shared by the temperature alert logic
package tae_pkg;

	localparam logic [7:0]  TAE_OFF_CONFIG = 8'h00;
	localparam logic [7:0]  TAE_OFF_HIGH   = 8'h04;
	localparam logic [7:0]  TAE_OFF_LOW    = 8'h08;
	localparam logic [7:0]  TAE_OFF_CRIT   = 8'h0c;
	localparam logic [7:0]  TAE_OFF_TEMP   = 8'h10;

	localparam int TAE_CFG_MODE      = 0;
	localparam int TAE_CFG_POL       = 1;
	localparam int TAE_CFG_CRIT_ONLY = 2;
	localparam int TAE_CFG_EN        = 3;
	localparam int TAE_CFG_STATUS    = 4;
	localparam int TAE_CFG_CLEAR     = 5;
	localparam int TAE_CFG_SHUTDOWN  = 8;
	localparam int TAE_CFG_HYST_LSB  = 9;
	localparam int TAE_LIM_LSB       = 2;
	localparam int TAE_LIM_MSB       = 12;
	localparam int TAE_TEMP_CRIT     = 15;
	localparam int TAE_TEMP_HIGH     = 14;
	localparam int TAE_TEMP_LOW      = 13;

	localparam logic [15:0] TAE_RST_CONFIG = 16'h0000;
	localparam logic [10:0] TAE_RST_LIMIT  = 11'h000;
	localparam logic [12:0] TAE_RST_TEMP   = 13'h0000;

	// hysteresis in sixteenths of a degree, the temperature lsb
	localparam logic [12:0] TAE_HYST_1P5 = 13'h0018;
	localparam logic [12:0] TAE_HYST_3   = 13'h0030;
	localparam logic [12:0] TAE_HYST_6   = 13'h0060;

	function automatic logic [12:0] tae_hyst(input logic [1:0] code);
		unique case (code)
			2'b00: tae_hyst = 13'h0000;
			2'b01: tae_hyst = TAE_HYST_1P5;
			2'b10: tae_hyst = TAE_HYST_3;
			2'b11: tae_hyst = TAE_HYST_6;
		endcase
	endfunction

	// two's complement 13-bit value widened so limit +/- hysteresis fits
	function automatic logic signed [14:0] tae_s15(input logic [12:0] v);
		tae_s15 = signed'({{2{v[12]}}, v});
	endfunction

	function automatic logic [12:0] tae_lim13(input logic [10:0] lim);
		tae_lim13 = {lim, 2'b00};
	endfunction

endpackage

// ==== rtl/tae_trip.sv ====
// one trip comparator with hysteresis, updated on each evaluation strobe
`timescale 1ns/10ps
module tae_trip
	import tae_pkg::*;
#(
	parameter logic ABOVE = 1'b1,
	parameter logic INCL  = 1'b0
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        eval,
	input  wire logic [12:0] value,
	input  wire logic [10:0] limit,
	input  wire logic [1:0]  hyst,
	output logic             flag
);

	typedef struct packed {
		logic tripped;
	} tae_trip_t;

	tae_trip_t st;
	tae_trip_t next_st;

	logic signed [14:0] v;
	logic signed [14:0] lim;
	logic signed [14:0] h;
	logic               trip;
	logic               release_ok;

	always_comb begin
		v   = tae_s15(value);
		lim = tae_s15(tae_lim13(limit));
		h   = tae_s15(tae_hyst(hyst));
		if (ABOVE) begin
			trip       = INCL ? (v >= lim) : (v > lim);
			release_ok = INCL ? (v < lim - h) : (v <= lim - h);
		end else begin
			trip       = v < lim;
			release_ok = v >= lim + h;
		end
		next_st = st;
		if (eval) begin
			if (trip)
				next_st.tripped = 1'b1;
			else if (release_ok)
				next_st.tripped = 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			st <= '0;
		else
			st <= next_st;
	end

	assign flag = st.tripped;

endmodule

// ==== rtl/tae_alert.sv ====
// temperature alert event logic with an ahb-lite register slave
`timescale 1ns/10ps
module tae_alert
	import tae_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic [12:0] temp_sample,
	input  wire logic        temp_sample_valid,
	output logic             converter_enable,
	output logic             alert_o,
	output logic             alert_oe
);

	typedef struct packed {
		logic        cfg_mode;
		logic        cfg_pol;
		logic        cfg_crit_only;
		logic        cfg_alert_en;
		logic        sensor_shutdown_bit;
		logic [1:0]  cfg_hyst;
		logic [10:0] high_limit;
		logic [10:0] low_limit;
		logic [10:0] critical_limit;
		logic [12:0] temperature_data_register;
		logic        sample_new;
		logic        lim_written;
		logic        ev_latched;
		logic        clear_pending;
		logic        win_prev;
		logic        crit_prev;
		logic        ap_valid;
		logic        ap_write;
		logic [7:0]  ap_addr;
		logic        status;
		logic        pin_oe;
		logic [31:0] rdata;
	} tae_state_t;

	tae_state_t st;
	tae_state_t next_st;

	logic addr_ok;
	logic wr_phase;
	logic cfg_wr;
	logic wr_clear;
	logic lim_wr;
	logic eval;
	logic hi_f;
	logic lo_f;
	logic crit_f;
	logic win_now;
	logic int_eff;
	logic event_now;
	logic assert_now;
	logic drive;

	assign addr_ok  = hsel & htrans[1] & hready;
	assign wr_phase = st.ap_valid & st.ap_write;
	assign cfg_wr   = wr_phase & (st.ap_addr == TAE_OFF_CONFIG);
	assign wr_clear = cfg_wr & hwdata[TAE_CFG_CLEAR];
	assign lim_wr   = wr_phase & ((st.ap_addr == TAE_OFF_HIGH) |
		(st.ap_addr == TAE_OFF_LOW) | (st.ap_addr == TAE_OFF_CRIT));

	// frozen during shutdown so the pin keeps its pre-shutdown level
	assign eval = ~st.sensor_shutdown_bit &
		(st.sample_new | st.lim_written);

	tae_trip #(
		.ABOVE (1'b1),
		.INCL  (1'b0)
	) u_high (
		.hclk    (hclk),
		.hresetn (hresetn),
		.eval    (eval),
		.value   (st.temperature_data_register),
		.limit   (st.high_limit),
		.hyst    (st.cfg_hyst),
		.flag    (hi_f)
	);

	tae_trip #(
		.ABOVE (1'b0),
		.INCL  (1'b0)
	) u_low (
		.hclk    (hclk),
		.hresetn (hresetn),
		.eval    (eval),
		.value   (st.temperature_data_register),
		.limit   (st.low_limit),
		.hyst    (st.cfg_hyst),
		.flag    (lo_f)
	);

	tae_trip #(
		.ABOVE (1'b1),
		.INCL  (1'b1)
	) u_crit (
		.hclk    (hclk),
		.hresetn (hresetn),
		.eval    (eval),
		.value   (st.temperature_data_register),
		.limit   (st.critical_limit),
		.hyst    (st.cfg_hyst),
		.flag    (crit_f)
	);

	assign win_now   = hi_f | lo_f;
	assign int_eff   = st.cfg_mode & ~st.cfg_crit_only;
	assign event_now = int_eff & ((win_now != st.win_prev) |
		(crit_f & ~st.crit_prev));

	always_comb begin
		if (st.cfg_crit_only)
			assert_now = crit_f;
		else if (st.cfg_mode)
			assert_now = st.ev_latched | crit_f;
		else
			assert_now = win_now | crit_f;
	end

	assign drive = st.cfg_alert_en & assert_now;

	always_comb begin
		next_st             = st;
		next_st.lim_written = lim_wr;
		next_st.sample_new  = 1'b0;
		next_st.win_prev    = win_now;
		next_st.crit_prev   = crit_f;
		next_st.ap_valid    = addr_ok;
		if (addr_ok) begin
			next_st.ap_write = hwrite;
			next_st.ap_addr  = haddr[7:0];
		end
		if (temp_sample_valid && !st.sensor_shutdown_bit) begin
			next_st.temperature_data_register = temp_sample;
			next_st.sample_new = 1'b1;
		end
		if (cfg_wr) begin
			next_st.cfg_mode      = hwdata[TAE_CFG_MODE];
			next_st.cfg_pol       = hwdata[TAE_CFG_POL];
			next_st.cfg_crit_only = hwdata[TAE_CFG_CRIT_ONLY];
			next_st.cfg_alert_en  = hwdata[TAE_CFG_EN];
			next_st.sensor_shutdown_bit = hwdata[TAE_CFG_SHUTDOWN];
			next_st.cfg_hyst = hwdata[TAE_CFG_HYST_LSB +: 2];
		end
		if (wr_phase && st.ap_addr == TAE_OFF_HIGH)
			next_st.high_limit = hwdata[TAE_LIM_MSB:TAE_LIM_LSB];
		if (wr_phase && st.ap_addr == TAE_OFF_LOW)
			next_st.low_limit = hwdata[TAE_LIM_MSB:TAE_LIM_LSB];
		if (wr_phase && st.ap_addr == TAE_OFF_CRIT)
			next_st.critical_limit = hwdata[TAE_LIM_MSB:TAE_LIM_LSB];
		// the latch only lives in interrupt mode; elsewhere clears are moot
		if (!int_eff) begin
			next_st.ev_latched    = 1'b0;
			next_st.clear_pending = 1'b0;
		end else begin
			if (wr_clear) begin
				if (crit_f)
					next_st.clear_pending = 1'b1;
				else
					next_st.ev_latched = 1'b0;
			end
			if (st.clear_pending && !crit_f) begin
				next_st.ev_latched    = 1'b0;
				next_st.clear_pending = 1'b0;
			end
			// a new crossing beats a clear in the same cycle
			if (event_now)
				next_st.ev_latched = 1'b1;
		end
		next_st.status = drive;
		next_st.pin_oe = st.cfg_pol ? ~drive : drive;
		// read data built from the updated state so write-then-read is safe
		next_st.rdata = 32'h0000_0000;
		if (addr_ok && !hwrite) begin
			case (haddr[7:0])
				TAE_OFF_CONFIG: begin
					next_st.rdata[TAE_CFG_MODE]      = next_st.cfg_mode;
					next_st.rdata[TAE_CFG_POL]       = next_st.cfg_pol;
					next_st.rdata[TAE_CFG_CRIT_ONLY] = next_st.cfg_crit_only;
					next_st.rdata[TAE_CFG_EN]        = next_st.cfg_alert_en;
					next_st.rdata[TAE_CFG_STATUS]    = st.status;
					next_st.rdata[TAE_CFG_SHUTDOWN] =
						next_st.sensor_shutdown_bit;
					next_st.rdata[TAE_CFG_HYST_LSB +: 2] = next_st.cfg_hyst;
				end
				TAE_OFF_HIGH:
					next_st.rdata[12:0] = tae_lim13(next_st.high_limit);
				TAE_OFF_LOW:
					next_st.rdata[12:0] = tae_lim13(next_st.low_limit);
				TAE_OFF_CRIT:
					next_st.rdata[12:0] = tae_lim13(next_st.critical_limit);
				TAE_OFF_TEMP: begin
					next_st.rdata[12:0] = st.temperature_data_register;
					next_st.rdata[TAE_TEMP_CRIT] = crit_f;
					next_st.rdata[TAE_TEMP_HIGH] = hi_f;
					next_st.rdata[TAE_TEMP_LOW]  = lo_f;
				end
				default:
					next_st.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= '0;
			st.cfg_hyst <= TAE_RST_CONFIG[TAE_CFG_HYST_LSB +: 2];
			st.high_limit <= TAE_RST_LIMIT;
			st.low_limit <= TAE_RST_LIMIT;
			st.critical_limit <= TAE_RST_LIMIT;
			st.temperature_data_register <= TAE_RST_TEMP;
		end else begin
			st <= next_st;
		end
	end

	// zero-wait slave; transfer size is not checked, words only
	assign hreadyout        = 1'b1;
	assign hresp            = 1'b0;
	assign hrdata           = st.rdata;
	assign converter_enable = ~st.sensor_shutdown_bit;
	// open drain: the pin is only ever pulled low
	assign alert_o          = 1'b0;
	assign alert_oe         = st.pin_oe;

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	sequence s_clear_req;
		int_eff && wr_clear;
	endsequence

	sequence s_crit_gone;
		st.clear_pending && !crit_f && !event_now;
	endsequence

	property p_clear_now;
		s_clear_req and (!crit_f && !event_now) |=> !st.ev_latched;
	endproperty
	a_clear_now: assert property (p_clear_now)
		else $error("clear below critical did not take effect");

	property p_clear_held;
		s_clear_req and (crit_f && st.ev_latched)
			|=> st.clear_pending && st.ev_latched;
	endproperty
	a_clear_held: assert property (p_clear_held)
		else $error("clear above critical not held pending");

	property p_pending_exec;
		s_crit_gone |=> !st.ev_latched && !st.clear_pending;
	endproperty
	a_pending_exec: assert property (p_pending_exec)
		else $error("pending clear not executed after critical dropped");

	property p_crit_holds;
		st.cfg_mode && !st.cfg_crit_only && st.cfg_alert_en && crit_f
			&& !cfg_wr |=> st.status;
	endproperty
	a_crit_holds: assert property (p_crit_holds)
		else $error("alert released while above critical");

	property p_event_latch;
		int_eff && st.cfg_alert_en && (win_now != st.win_prev) && !cfg_wr
			|=> st.ev_latched ##1 st.status;
	endproperty
	a_event_latch: assert property (p_event_latch)
		else $error("window crossing did not raise the alert");

	property p_comparator;
		!st.cfg_mode && !st.cfg_crit_only && st.cfg_alert_en
			|=> st.status == $past(win_now | crit_f);
	endproperty
	a_comparator: assert property (p_comparator)
		else $error("comparator alert does not follow the window");

	property p_crit_only;
		st.cfg_crit_only && !crit_f |=> !st.status;
	endproperty
	a_crit_only: assert property (p_crit_only)
		else $error("critical-only alert asserted below critical");

	property p_ignore_clear;
		!int_eff && wr_clear |=> !st.clear_pending && !st.ev_latched;
	endproperty
	a_ignore_clear: assert property (p_ignore_clear)
		else $error("clear acted outside interrupt mode");

	property p_freeze;
		st.sensor_shutdown_bit |=> $stable(st.temperature_data_register);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("temperature changed during shutdown");

	property p_shutdown_pin;
		st.sensor_shutdown_bit && $past(st.sensor_shutdown_bit) && !cfg_wr
			&& !$past(cfg_wr) && !st.clear_pending |=> $stable(alert_oe);
	endproperty
	a_shutdown_pin: assert property (p_shutdown_pin)
		else $error("alert pin moved during shutdown");

	property p_limit_eval;
		lim_wr && !st.sensor_shutdown_bit && !cfg_wr |=> eval;
	endproperty
	a_limit_eval: assert property (p_limit_eval)
		else $error("limit write did not trigger evaluation");

	property p_sample_eval;
		temp_sample_valid && !st.sensor_shutdown_bit && !cfg_wr
			|=> st.temperature_data_register == $past(temp_sample) ##0 eval;
	endproperty
	a_sample_eval: assert property (p_sample_eval)
		else $error("new sample not recorded and evaluated");

	property p_pin_polarity;
		1'b1 |=> alert_oe == ($past(st.cfg_pol) ^ st.status);
	endproperty
	a_pin_polarity: assert property (p_pin_polarity)
		else $error("alert pin level disagrees with polarity");

	property p_shutdown_req;
		cfg_wr && hwdata[TAE_CFG_SHUTDOWN] |=> !converter_enable;
	endproperty
	a_shutdown_req: assert property (p_shutdown_req)
		else $error("shutdown request did not stop the converter");

	property p_disabled;
		!st.cfg_alert_en |=> !st.status;
	endproperty
	a_disabled: assert property (p_disabled)
		else $error("disabled alert output still asserted");

	property p_latch_scope;
		!st.cfg_mode || st.cfg_crit_only
			|=> !st.ev_latched && !st.clear_pending;
	endproperty
	a_latch_scope: assert property (p_latch_scope)
		else $error("event latch alive outside interrupt mode");

endmodule

// ==== bench/tae_host_line.sv ====
// host-side model of the shared open-drain alert line
`timescale 1ns/10ps
module tae_host_line (
	input  wire logic alert_o,
	input  wire logic alert_oe,
	output logic      alert_line
);
	// board pull-up: a released pin reads high, never the last driven value
	assign alert_line = alert_oe ? alert_o : 1'b1;
endmodule

// ==== bench/tae_alert_tb.sv ====
// self-checking bench for the temperature alert logic
`timescale 1ns/10ps
module tae_alert_tb
	import tae_pkg::*;
;
	localparam logic [1:0] ON_LO  = 2'b10;
	localparam logic [1:0] OFF_LO = 2'b11;
	logic        hclk, hresetn, hsel, hwrite, tvalid, rd_dph, look;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [12:0] tsamp;
	logic        hreadyout, hresp, ce, a_o, a_oe, line;
	int          fail_count = 0, check_count = 0, cyc = 0, seed = 52;
	logic [31:0] rq[$];
	logic [1:0]  lq[$];

	tae_alert dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .temp_sample(tsamp),
		.temp_sample_valid(tvalid), .converter_enable(ce),
		.alert_o(a_o), .alert_oe(a_oe));
	tae_host_line host_u (.alert_o(a_o), .alert_oe(a_oe), .alert_line(line));

	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic cmp_word(input logic [31:0] e, input logic [31:0] s);
		check_count++;
		if (s !== e) begin
			fail_count++;
			$display("BAD hrdata exp %h got %h", e, s);
		end
	endtask

	task automatic cmp_pin(input logic [1:0] e, input logic [1:0] s);
		check_count++;
		if (s !== e) begin
			fail_count++;
			$display("BAD enable_and_line exp %b got %b", e, s);
		end
	endtask

	task automatic cmp_resp(input logic e, input logic s);
		check_count++;
		if (s !== e) begin
			fail_count++;
			$display("BAD hresp exp %b got %b", e, s);
		end
	endtask

	// monitor: oldest note is compared whenever a result is presented
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (rd_dph) begin
			cmp_word(rq.pop_front(), hrdata);
			cmp_resp(1'b0, hresp);
		end
		if (look)
			cmp_pin(lq.pop_front(), {ce, line});
		// ceiling far above the few hundred cycles the scenarios need
		if (cyc == 6000) begin
			fail_count++;
			end_sim;
		end
	end

	task automatic bus(input logic w, input logic [7:0] a,
			input logic [31:0] d, input logic [31:0] e);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= {24'h000000, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		if (!w) begin
			rq.push_back(e);
			rd_dph <= 1'b1;
		end
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd_dph <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, e);
	endtask

	// config and limit changes reach the pin within four edges
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 32'h0);
		repeat (4) @(posedge hclk);
	endtask

	task automatic cf(input logic [31:0] d);
		wr(TAE_OFF_CONFIG, d);
	endtask

	task automatic samp(input logic [12:0] t);
		tsamp  <= t;
		tvalid <= 1'b1;
		@(posedge hclk);
		tvalid <= 1'b0;
		repeat (6) @(posedge hclk);
	endtask

	task automatic chk(input logic [1:0] e);
		lq.push_back(e);
		look <= 1'b1;
		@(posedge hclk);
		look <= 1'b0;
	endtask

	initial begin
		logic [12:0] t;
		logic        in_win;
		int          hv[4];
		hv = '{0, 24, 48, 96};
		{hsel, hwrite, tvalid, rd_dph, look, hresetn} = 6'b0;
		haddr = 32'h0;
		hwdata = 32'h0;
		htrans = 2'b00;
		hsize = 3'b010;
		tsamp = 13'h0000;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(TAE_OFF_CONFIG, {16'h0000, TAE_RST_CONFIG});
		rd(8'h14, 32'h0);
		wr(TAE_OFF_HIGH, 32'hffffffff);
		rd(TAE_OFF_HIGH, 32'h00001ffc);
		wr(TAE_OFF_HIGH, 32'h320);
		wr(TAE_OFF_LOW, 32'h190);
		wr(TAE_OFF_CRIT, 32'h4b0);
		cf(32'h08);
		samp(13'h200); chk(OFF_LO);
		samp(13'h3c0); chk(ON_LO);
		samp(13'h200); chk(OFF_LO);
		samp(13'h100); chk(ON_LO);
		cf(32'h28); chk(ON_LO);
		rd(TAE_OFF_CONFIG, 32'h18);
		wr(TAE_OFF_LOW, 32'h080); chk(OFF_LO);
		wr(TAE_OFF_LOW, 32'h190); chk(ON_LO);
		samp(13'h200); chk(OFF_LO);
		cf(32'h0a); chk(2'b10);
		samp(13'h3c0); chk(2'b11);
		cf(32'h02); chk(2'b10);
		cf(32'h09);
		samp(13'h200); chk(ON_LO);
		cf(32'h29); chk(OFF_LO);
		samp(13'h3c0); chk(ON_LO);
		cf(32'h29); chk(OFF_LO);
		samp(13'h500); chk(ON_LO);
		cf(32'h29); chk(ON_LO);
		samp(13'h400); chk(OFF_LO);
		samp(13'h200); chk(ON_LO);
		cf(32'h29); chk(OFF_LO);
		cf(32'h0c);
		samp(13'h3c0); chk(OFF_LO);
		samp(13'h500); chk(ON_LO);
		cf(32'h2c); chk(ON_LO);
		samp(13'h400); chk(OFF_LO);
		for (int c = 0; c < 4; c++) begin
			cf({21'h0, c[1:0], 9'h008});
			samp(13'h330); chk(ON_LO);
			samp(13'h321 - hv[c][12:0]); chk(ON_LO);
			samp(13'h320 - hv[c][12:0]); chk(OFF_LO);
		end
		cf(32'h08);
		samp(13'h3c0); chk(ON_LO);
		cf(32'h108); chk(2'b00);
		samp(13'h200); chk(2'b00);
		rd(TAE_OFF_TEMP, 32'h43c0);
		rd(TAE_OFF_CONFIG, 32'h118);
		// host frees the shared line while the sensor sleeps
		cf(32'h100); chk(2'b01);
		cf(32'h08); chk(ON_LO);
		for (int i = 0; i < 8; i++) begin
			t = 13'($random(seed));
			samp(t);
			in_win = $signed(t) <= 13'sh0320 && $signed(t) >= 13'sh0190;
			chk({1'b1, in_win});
		end
		end_sim;
	end
endmodule
